// [lpm_ctrl.sv]
// Purpose: Deep-sleep, idle and slow mode control with the misc register.
// Assumes: CPU and peripherals share clk; only the irq pin is asynchronous.
// Notes: clk keeps running so wake sources can be seen while osc_run is low.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps

// Notes on behaviour
// - Deep-sleep request accepted only while CAN controller reports sleep.
// - Deep-sleep stops oscillator, timer, serial interface and converter.
// - Deep-sleep ends only on CAN, wired-OR, external pin interrupt or reset.
// - Wake vectors through interrupt pair or reset pair.
// - Entering deep-sleep clears the CPU interrupt mask bit.
// - Entering deep-sleep clears slow select so stabilisation runs at nominal speed.
// - After deep-sleep, CPU held 16 or 4064 internal cycles by option.
// - CPU resumes by servicing waking interrupt or reset; stacking only at exit.
// - Deep-sleep resets watchdog, EEPROM read-only, converter off, outputs hold.
// - Idle suspends CPU; peripherals run; watchdog follows manufacturing option.
// - Entering idle clears interrupt mask bit, irq enable untouched.
// - Any interrupt or reset ends idle; interrupt exit keeps other state.
// - Timer keeps running in idle and cannot be disabled there.
// - Slow select inserts divide-by-16 between oscillator and bus clock.
// - Slow mode slows everything except the CAN controller clock.
// - Slow select cleared by external and power-on reset.
// - Edge and level select choose pin trigger; irq enable gates it.
// - Interrupt option writes take effect only while mask bit is set.
// - Changing trigger option clears any pending external interrupt.
// - CAN clock is oscillator over two, independent of bus ratio.
module lpm_ctrl #(
   parameter logic [1:0] DIV_SEL = 2'h0,
   parameter logic STAB_IS_LONG = 1'b1,
   parameter logic WDOG_IN_IDLE = 1'b0
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata_r,
   input wire logic deep_req,
   input wire logic idle_req,
   input wire logic cpu_ibit,
   input wire logic can_asleep,
   input wire logic can_irq,
   input wire logic wor_irq,
   input wire logic periph_irq,
   input wire logic irq_pin_n,
   input wire logic ext_irq_ack,
   input wire logic timer_sw_en,
   output logic osc_run_r,
   output logic cpu_clk_en_r,
   output logic periph_clk_en_r,
   output logic timer_clk_en_r,
   output logic can_clk_en_r,
   output logic clr_ibit_r,
   output logic resume_r,
   output logic stack_r,
   output logic [15:0] vector_r,
   output logic ext_irq_pend_r,
   output logic wdog_rst_r,
   output logic wdog_run_r,
   output logic eeprom_ro_r,
   output logic adc_en_r,
   output logic plm_hold_r
);

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic [1:0] rst_sync_r;
   wire logic rst_n;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         rst_sync_r <= 2'b00;
      else
         rst_sync_r <= {rst_sync_r[0], 1'b1};
   end

   assign rst_n = rst_sync_r[1];

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   lpm_pkg::lpm_state_t state_r;
   lpm_pkg::lpm_state_t state_nxt;
   logic edge_sel_r;
   logic level_sel_r;
   logic irq_en_r;
   logic slow_r;
   logic pin_meta_r;
   logic pin_sync_r;
   logic pin_prev_r;
   logic refused_r;
   logic wake_irq_r;
   logic [11:0] stab_cnt_r;
   wire logic bus_en;
   wire logic can_en;
   wire logic wr_misc;
   wire logic opt_wr_ok;
   wire logic opt_change;
   wire logic pin_act;
   wire logic pin_prev_act;
   wire logic trig;
   wire logic pend_set;
   wire logic in_run;
   wire logic in_idle;
   wire logic in_deep;
   wire logic in_stab;
   wire logic deep_ok;
   wire logic deep_enter;
   wire logic idle_enter;
   wire logic deep_wake;
   wire logic idle_wake;
   wire logic stab_done;
   wire logic osc_on;
   wire logic [11:0] stab_last;
   wire logic [7:0] misc_val;
   wire logic [7:0] stat_val;
   wire logic [7:0] rd_val;

   // ----------------------------------------
   // Register decode
   // ----------------------------------------
   assign wr_misc = reg_wr & (reg_addr == lpm_pkg::MISC_ADDR);
   assign opt_wr_ok = wr_misc & cpu_ibit;
   assign opt_change = opt_wr_ok &
      ((reg_wdata[lpm_pkg::MISC_EDGE_BIT] != edge_sel_r) |
       (reg_wdata[lpm_pkg::MISC_LEVEL_BIT] != level_sel_r));

   assign misc_val = {1'b0, edge_sel_r, level_sel_r, irq_en_r,
                      2'b00, slow_r, 1'b0};
   assign stat_val = {2'b00, wake_irq_r, refused_r, ext_irq_pend_r,
                      osc_run_r, state_r};
   assign rd_val = (reg_addr == lpm_pkg::MISC_ADDR) ? misc_val :
                   (reg_addr == lpm_pkg::STAT_ADDR) ? stat_val : 8'h00;

   // ----------------------------------------
   // External interrupt pin
   // ----------------------------------------
   // Edge select picks edge or level; level select picks the polarity
   assign pin_act = level_sel_r ? pin_sync_r : ~pin_sync_r;
   assign pin_prev_act = level_sel_r ? pin_prev_r : ~pin_prev_r;
   assign trig = edge_sel_r ? (pin_act & ~pin_prev_act) : pin_act;
   assign pend_set = irq_en_r & trig;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_meta_r <= 1'b1;
         pin_sync_r <= 1'b1;
         pin_prev_r <= 1'b1;
      end
      else
      begin
         pin_meta_r <= irq_pin_n;
         pin_sync_r <= pin_meta_r;
         pin_prev_r <= pin_sync_r;
      end
   end

   // Option change clears outright; a new event still beats an acknowledge
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ext_irq_pend_r <= 1'b0;
      else if (opt_change)
         ext_irq_pend_r <= 1'b0;
      else if (pend_set)
         ext_irq_pend_r <= 1'b1;
      else if (ext_irq_ack)
         ext_irq_pend_r <= 1'b0;
   end

   // ----------------------------------------
   // Miscellaneous register
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         edge_sel_r <= lpm_pkg::MISC_RST[lpm_pkg::MISC_EDGE_BIT];
         level_sel_r <= lpm_pkg::MISC_RST[lpm_pkg::MISC_LEVEL_BIT];
         irq_en_r <= lpm_pkg::MISC_RST[lpm_pkg::MISC_IRQEN_BIT];
      end
      else if (opt_wr_ok)
      begin
         edge_sel_r <= reg_wdata[lpm_pkg::MISC_EDGE_BIT];
         level_sel_r <= reg_wdata[lpm_pkg::MISC_LEVEL_BIT];
         irq_en_r <= reg_wdata[lpm_pkg::MISC_IRQEN_BIT];
      end
   end

   // Deep-sleep entry wins over a write in the same cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         slow_r <= lpm_pkg::MISC_RST[lpm_pkg::MISC_SLOW_BIT];
      else if (deep_enter)
         slow_r <= 1'b0;
      else if (wr_misc)
         slow_r <= reg_wdata[lpm_pkg::MISC_SLOW_BIT];
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata_r <= 8'h00;
      else if (reg_rd)
         reg_rdata_r <= rd_val;
   end

   // ----------------------------------------
   // Clock divider
   // ----------------------------------------
   // Oscillator is stopped only while in deep-sleep
   assign osc_on = ~in_deep;

   lpm_clkdiv #(
      .DIV_SEL(DIV_SEL)
   ) u_div (
      .clk(clk),
      .rst_n(rst_n),
      .run(osc_on),
      .slow(slow_r),
      .bus_en_r(bus_en),
      .can_en_r(can_en)
   );

   // ----------------------------------------
   // Mode sequencing
   // ----------------------------------------
   assign in_run = state_r == lpm_pkg::LPM_RUN;
   assign in_idle = state_r == lpm_pkg::LPM_IDLE;
   assign in_deep = state_r == lpm_pkg::LPM_DEEP;
   assign in_stab = state_r == lpm_pkg::LPM_STAB;

   assign deep_ok = can_asleep;
   assign deep_enter = in_run & deep_req & deep_ok;
   assign idle_enter = in_run & idle_req & ~deep_req;
   // Peripheral interrupts cannot arrive with the oscillator stopped
   assign deep_wake = in_deep & (can_irq | wor_irq | ext_irq_pend_r);
   assign idle_wake = in_idle &
      (can_irq | wor_irq | ext_irq_pend_r | periph_irq);

   // Slow select is already clear here, so these are nominal bus cycles
   assign stab_last = (STAB_IS_LONG ? lpm_pkg::STAB_LONG
                                    : lpm_pkg::STAB_SHORT) - 12'h001;
   assign stab_done = in_stab & bus_en & (stab_cnt_r == stab_last);

   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         lpm_pkg::LPM_RUN:
         begin
            if (deep_enter)
               state_nxt = lpm_pkg::LPM_DEEP;
            else if (idle_enter)
               state_nxt = lpm_pkg::LPM_IDLE;
         end
         lpm_pkg::LPM_IDLE:
         begin
            if (idle_wake)
               state_nxt = lpm_pkg::LPM_RUN;
         end
         lpm_pkg::LPM_DEEP:
         begin
            if (deep_wake)
               state_nxt = lpm_pkg::LPM_STAB;
         end
         lpm_pkg::LPM_STAB:
         begin
            if (stab_done)
               state_nxt = lpm_pkg::LPM_RUN;
         end
      endcase
   end

   // Reset is itself a wake: it starts in stabilisation with the reset vector
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= lpm_pkg::LPM_STAB;
         stab_cnt_r <= 12'h000;
         wake_irq_r <= 1'b0;
         refused_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         if (!in_stab)
            stab_cnt_r <= 12'h000;
         else if (bus_en)
            stab_cnt_r <= stab_cnt_r + 12'h001;
         if (deep_wake | idle_wake)
            wake_irq_r <= 1'b1;
         // Refusal stays visible until a later request is accepted
         if (in_run & deep_req)
            refused_r <= ~deep_ok;
      end
   end

   // ----------------------------------------
   // CPU handshake
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         clr_ibit_r <= 1'b0;
         resume_r <= 1'b0;
         stack_r <= 1'b0;
         vector_r <= lpm_pkg::VEC_RST;
      end
      else
      begin
         clr_ibit_r <= deep_enter | idle_enter;
         // Stacking is asked for only at the moment of exit
         resume_r <= stab_done | idle_wake;
         stack_r <= (stab_done & wake_irq_r) | idle_wake;
         if (stab_done | idle_wake)
            vector_r <= (idle_wake | wake_irq_r) ? lpm_pkg::VEC_IRQ
                                                 : lpm_pkg::VEC_RST;
      end
   end

   // ----------------------------------------
   // Clock gating and peripheral controls
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         osc_run_r <= 1'b1;
         cpu_clk_en_r <= 1'b0;
         periph_clk_en_r <= 1'b0;
         timer_clk_en_r <= 1'b0;
         can_clk_en_r <= 1'b0;
      end
      else
      begin
         osc_run_r <= osc_on;
         // CPU runs only in normal operation, held through stabilisation
         cpu_clk_en_r <= bus_en & in_run;
         periph_clk_en_r <= bus_en & osc_on;
         timer_clk_en_r <= bus_en & osc_on & (timer_sw_en | in_idle);
         can_clk_en_r <= can_en;
      end
   end

   // Deep-sleep effects hold while stopped; idle changes only wdog_run_r, which follows WDOG_IN_IDLE
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wdog_rst_r <= 1'b1;
         wdog_run_r <= 1'b0;
         eeprom_ro_r <= 1'b0;
         adc_en_r <= 1'b1;
         plm_hold_r <= 1'b0;
      end
      else
      begin
         wdog_rst_r <= in_deep;
         wdog_run_r <= in_idle ? WDOG_IN_IDLE : ~in_deep;
         eeprom_ro_r <= in_deep;
         adc_en_r <= ~in_deep;
         plm_hold_r <= in_deep;
      end
   end

endmodule // lpm_ctrl

// [lpm_pkg.sv]
// Purpose: Constants and types shared by the low power mode controller.
// Assumes: An 8-bit register port and one oscillator-rate clock.
// Notes: The two vector bases are the low bytes of each vector pair.
package lpm_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] MISC_ADDR = 8'h0C;
   localparam logic [7:0] STAT_ADDR = 8'h0D;
   localparam logic [7:0] MISC_RST = 8'h10;

   localparam int MISC_EDGE_BIT = 6;
   localparam int MISC_LEVEL_BIT = 5;
   localparam int MISC_IRQEN_BIT = 4;
   localparam int MISC_SLOW_BIT = 1;

   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_OSC_BIT = 2;
   localparam int STAT_PEND_BIT = 3;
   localparam int STAT_REFUSE_BIT = 4;
   localparam int STAT_WAKEIRQ_BIT = 5;

   // ----------------------------------------
   // Vectors
   // ----------------------------------------
   localparam logic [15:0] VEC_IRQ = 16'h3FFA;
   localparam logic [15:0] VEC_RST = 16'h3FFE;

   // ----------------------------------------
   // Timing, in internal (bus) cycles; the slow prescaler count in oscillator cycles
   // ----------------------------------------
   localparam logic [11:0] STAB_SHORT = 12'h010;
   localparam logic [11:0] STAB_LONG = 12'hFE0;
   localparam logic [3:0] SLOW_PRE_LAST = 4'hF;

   // ----------------------------------------
   // Operating states
   // ----------------------------------------
   typedef enum logic [1:0] {
      LPM_RUN,
      LPM_IDLE,
      LPM_DEEP,
      LPM_STAB
   } lpm_state_t;

   // Bus divide ratio chosen at manufacture: /2, /4, /8 or /10
   function automatic logic [3:0] bus_ratio(input logic [1:0] sel);
      logic [3:0] r;
      r = 4'h2;
      unique case (sel)
         2'h0: r = 4'h2;
         2'h1: r = 4'h4;
         2'h2: r = 4'h8;
         2'h3: r = 4'hA;
      endcase
      return r;
   endfunction

endpackage

// [lpm_clkdiv.sv]
// Purpose: Oscillator divider giving bus and CAN clock enable pulses.
// Assumes: clk is the oscillator; run low models a stopped oscillator.
// Notes: Slow mode adds a divide-by-16 ahead of the bus divider only.
`timescale 1ns/1ps
module lpm_clkdiv #(
   parameter logic [1:0] DIV_SEL = 2'h0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic slow,
   output logic bus_en_r,
   output logic can_en_r
);

   logic [3:0] pre_cnt_r;
   logic [3:0] main_cnt_r;
   wire logic pre_tick;
   wire logic bus_last;

   assign pre_tick = run & (~slow | (pre_cnt_r == lpm_pkg::SLOW_PRE_LAST));
   assign bus_last = main_cnt_r == (lpm_pkg::bus_ratio(DIV_SEL) - 4'h1);

   // ----------------------------------------
   // Counters
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pre_cnt_r <= 4'h0;
         main_cnt_r <= 4'h0;
         bus_en_r <= 1'b0;
         can_en_r <= 1'b0;
      end
      else
      begin
         // A stopped or fast prescaler restarts from zero
         pre_cnt_r <= (run & slow) ? pre_cnt_r + 4'h1 : 4'h0;
         if (pre_tick)
            main_cnt_r <= bus_last ? 4'h0 : main_cnt_r + 4'h1;
         bus_en_r <= pre_tick & bus_last;
         // CAN clock is oscillator over two, blind to slow mode
         can_en_r <= run & ~can_en_r;
      end
   end

endmodule // lpm_clkdiv

// [lpm_ctrl_props.sv]
// Purpose: Port checker for lpm_ctrl
// Assumes: clk runs on through deep-sleep
// Notes: Bound to every lpm_ctrl at the foot
`timescale 1ns/1ps
module lpm_ctrl_props #(
   parameter logic [1:0] DIV_SEL = 2'h0,
   parameter logic STAB_IS_LONG = 1'b1,
   parameter logic WDOG_IN_IDLE = 1'b0
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic deep_req,
   input wire logic can_asleep,
   input wire logic can_irq,
   input wire logic wor_irq,
   input wire logic ext_irq_pend_r,
   input wire logic osc_run_r,
   input wire logic cpu_clk_en_r,
   input wire logic periph_clk_en_r,
   input wire logic timer_clk_en_r,
   input wire logic can_clk_en_r,
   input wire logic clr_ibit_r,
   input wire logic resume_r,
   input wire logic stack_r,
   input wire logic [15:0] vector_r,
   input wire logic wdog_rst_r,
   input wire logic wdog_run_r,
   input wire logic eeprom_ro_r,
   input wire logic adc_en_r,
   input wire logic plm_hold_r
);
   localparam int RATIO = (DIV_SEL == 2'h3) ? 10 : (2 << DIV_SEL);
   localparam int STAB = (STAB_IS_LONG ? 4064 : 16) * RATIO;
   logic [2:0] age_r;
   logic [15:0] since_r;
   wire woke = can_irq || wor_irq || ext_irq_pend_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Cycles since the oscillator restarted, cleared at resume
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         age_r <= 3'h0;
         since_r <= 16'h0000;
      end
      else
      begin
         if (age_r != 3'h7)
            age_r <= age_r + 3'h1;
         if ($rose(osc_run_r))
            since_r <= 16'h0001;
         else if (resume_r)
            since_r <= 16'h0000;
         else if (since_r != 16'h0000)
            since_r <= since_r + 16'h0001;
      end
   end
   a_deep_needs_can: assert property ($fell(osc_run_r) |->
      $past(deep_req && can_asleep, 2) || $past(deep_req && can_asleep, 3))
      else $error("oscillator stopped without accepted request");
   a_deep_clr_ibit: assert property ($fell(osc_run_r) |-> $past(clr_ibit_r) || $past(clr_ibit_r, 2))
      else $error("deep entry without mask clear");
   a_deep_gates_clk: assert property (!osc_run_r && !$past(osc_run_r) |->
      !(cpu_clk_en_r || periph_clk_en_r || timer_clk_en_r || can_clk_en_r))
      else $error("clock pulse while oscillator off");
   a_deep_effects: assert property (!osc_run_r && !$past(osc_run_r) |->
      wdog_rst_r && eeprom_ro_r && plm_hold_r && !adc_en_r && !wdog_run_r)
      else $error("deep-sleep side effects missing");
   a_wake_cause: assert property ($rose(osc_run_r) |-> $past(woke) || $past(woke, 2))
      else $error("oscillator restarted without wake source");
   a_vector_sel: assert property (resume_r |-> vector_r == (stack_r ? lpm_pkg::VEC_IRQ : lpm_pkg::VEC_RST))
      else $error("wrong resume vector");
   a_stack_resume: assert property (stack_r |-> resume_r)
      else $error("stacking outside resume");
   a_stab_delay: assert property (since_r != 16'h0000 |->
      since_r <= STAB + 8 && (!resume_r || since_r >= STAB - 4))
      else $error("stabilisation delay wrong");
   a_can_half: assert property (age_r == 3'h7 && osc_run_r && $past(osc_run_r) && $past(osc_run_r, 2) |->
      can_clk_en_r != $past(can_clk_en_r))
      else $error("CAN enable not every second clock");
   a_timer_bus: assert property (timer_clk_en_r |-> periph_clk_en_r)
      else $error("timer pulse off the bus tick");
   c_deep_entry: cover property ($fell(osc_run_r));
   c_irq_resume: cover property (resume_r && stack_r);
   c_rst_resume: cover property (resume_r && !stack_r);
endmodule // lpm_ctrl_props

bind lpm_ctrl lpm_ctrl_props #(.DIV_SEL(DIV_SEL), .STAB_IS_LONG(STAB_IS_LONG), .WDOG_IN_IDLE(WDOG_IN_IDLE))
   lpm_ctrl_props_i (.clk, .arst_n, .deep_req, .can_asleep, .can_irq, .wor_irq, .ext_irq_pend_r,
   .osc_run_r, .cpu_clk_en_r, .periph_clk_en_r, .timer_clk_en_r, .can_clk_en_r, .clr_ibit_r,
   .resume_r, .stack_r, .vector_r, .wdog_rst_r, .wdog_run_r, .eeprom_ro_r, .adc_en_r, .plm_hold_r);

// [lpm_cpu_model.sv]
// Purpose: CPU core stand-in issuing mode requests
// Assumes: Bench commands are one-cycle pulses
// Notes: Mask bit follows clear pulses and stacking
`timescale 1ns/1ps
module lpm_cpu_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic go_deep,
   input wire logic go_idle,
   input wire logic set_i,
   input wire logic clr_i,
   input wire logic clr_ibit_r,
   input wire logic stack_r,
   output logic deep_req,
   output logic idle_req,
   output logic cpu_ibit
);
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         deep_req <= 1'b0;
         idle_req <= 1'b0;
         cpu_ibit <= 1'b1;
      end
      else
      begin
         deep_req <= go_deep;
         idle_req <= go_idle;
         if (clr_ibit_r || clr_i)
            cpu_ibit <= 1'b0;
         else if (stack_r || set_i)
            cpu_ibit <= 1'b1; // Service entry masks again
      end
   end
endmodule // lpm_cpu_model

// [lpm_ctrl_tb.sv]
// Purpose: Self-checking bench for lpm_ctrl
// Assumes: DIV_SEL 0 and the short stabilisation option
// Notes: Random option values come from a fixed seed
`timescale 1ns/1ps
module lpm_ctrl_tb;
   localparam int STAB = 16 * 2;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic can_asleep = 1'b0;
   logic can_irq = 1'b0;
   logic wor_irq = 1'b0;
   logic periph_irq = 1'b0;
   logic irq_pin_n = 1'b1;
   logic ext_irq_ack = 1'b0;
   logic timer_sw_en = 1'b1;
   logic go_deep = 1'b0, go_idle = 1'b0, set_i = 1'b0, clr_i = 1'b0;
   logic deep_req, idle_req, cpu_ibit, osc_run_r, cpu_clk_en_r, periph_clk_en_r, timer_clk_en_r;
   logic can_clk_en_r, clr_ibit_r, resume_r, stack_r, ext_irq_pend_r, wdog_rst_r, wdog_run_r;
   logic eeprom_ro_r, adc_en_r, plm_hold_r;
   logic [15:0] vector_r;
   logic [7:0] reg_rdata_r, d;
   int num_errors = 0, n_tests = 0, seed = 609, c, i, r, np, nc, nt, nk;

   lpm_ctrl #(.DIV_SEL(2'h0), .STAB_IS_LONG(1'b0), .WDOG_IN_IDLE(1'b0)) lpm_ctrl_i (.clk, .arst_n,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r, .deep_req, .idle_req, .cpu_ibit,
      .can_asleep, .can_irq, .wor_irq, .periph_irq, .irq_pin_n, .ext_irq_ack, .timer_sw_en,
      .osc_run_r, .cpu_clk_en_r, .periph_clk_en_r, .timer_clk_en_r, .can_clk_en_r, .clr_ibit_r,
      .resume_r, .stack_r, .vector_r, .ext_irq_pend_r, .wdog_rst_r, .wdog_run_r, .eeprom_ro_r,
      .adc_en_r, .plm_hold_r);
   lpm_cpu_model lpm_cpu_model_i (.clk, .arst_n, .go_deep, .go_idle, .set_i, .clr_i,
      .clr_ibit_r, .stack_r, .deep_req, .idle_req, .cpu_ibit);

   initial
   begin
      forever #12.5 clk = ~clk;
   end

   // ------
   // Tasks
   // ------
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error %s: expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk) d = reg_rdata_r;
   endtask
   // Pulse one model command: 0 deep, 1 idle, 2 mask, 3 unmask
   task automatic cmd(input int k);
      @(posedge clk);
      {go_deep, go_idle, set_i, clr_i} <= 4'h8 >> k;
      @(posedge clk);
      {go_deep, go_idle, set_i, clr_i} <= 4'h0;
   endtask
   task automatic wait_res();
      c = 0;
      while (resume_r !== 1'b1 && c < 9000)
      begin
         @(negedge clk);
         c++;
      end
   endtask
   task automatic count();
      {np, nc, nt, nk} = {4{32'sh0}};
      repeat (40)
      begin
         @(negedge clk);
         np += periph_clk_en_r;
         nc += cpu_clk_en_r;
         nt += timer_clk_en_r;
         nk += can_clk_en_r;
      end
   endtask
   // Third pulse spacing, so a divider phase change has settled
   task automatic gap(input bit k, output int g);
      repeat (3)
      begin
         g = 0;
         do
         begin
            @(negedge clk);
            g++;
         end
         while ((k ? can_clk_en_r : periph_clk_en_r) !== 1'b1 && g < 99);
      end
   endtask
   task automatic do_reset();
      arst_n <= 1'b0;
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      wait_res();
      chk("reset resume", {vector_r[13:0], stack_r, resume_r}, {lpm_pkg::VEC_RST[13:0], 2'h1});
      repeat (3) @(posedge clk);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial
   begin
      #(25 * 20000);
      num_errors++;
      $display("Error watchdog: expected end seen timeout");
      conclude();
   end

   // ------
   // Scenarios
   // ------
   initial
   begin
      do_reset();
      rd(lpm_pkg::MISC_ADDR);
      chk("misc reset", {8'h00, d}, {8'h00, lpm_pkg::MISC_RST});
      rd(8'h3F);
      chk("unmapped", {8'h00, d}, 16'h0000);
      cmd(0);
      repeat (4) @(negedge clk);
      rd(lpm_pkg::STAT_ADDR);
      chk("refused", {8'h00, d}, 16'h0014);
      wr(lpm_pkg::MISC_ADDR, 8'h12);
      can_asleep <= 1'b1;
      cmd(0);
      repeat (4) @(negedge clk);
      chk("deep", {osc_run_r, wdog_rst_r, eeprom_ro_r, plm_hold_r, adc_en_r, wdog_run_r, cpu_ibit}, 16'h38);
      rd(lpm_pkg::MISC_ADDR);
      chk("slow cleared", {8'h00, d}, 16'h0010);
      @(posedge clk) periph_irq <= 1'b1;
      count();
      chk("deep quiet", {osc_run_r, 15'(np + nc + nt + nk)}, 16'h0000);
      r = $random(seed);
      @(posedge clk) {periph_irq, can_irq, wor_irq} <= r[0] ? 3'b010 : 3'b001;
      i = 0;
      while (osc_run_r !== 1'b1 && i < 99)
      begin
         @(negedge clk);
         i++;
      end
      wait_res();
      chk("deep wake", {vector_r[13:0], stack_r, c >= STAB - 4 && c <= STAB + 8}, {lpm_pkg::VEC_IRQ[13:0], 2'h3});
      @(posedge clk) {can_irq, wor_irq, timer_sw_en} <= 3'b000;
      $display("deep-sleep test done");
      cmd(1);
      // Last run-state CPU pulse may still be in flight for two edges
      repeat (2) @(posedge clk);
      count();
      chk("idle", {np > 0, nc == 0, nt > 0, wdog_run_r, cpu_ibit, osc_run_r}, 16'h0039);
      rd(lpm_pkg::MISC_ADDR);
      chk("idle misc", {8'h00, d}, 16'h0010);
      @(posedge clk) periph_irq <= 1'b1;
      wait_res();
      chk("idle wake", {vector_r[13:0], stack_r, c <= 4}, {lpm_pkg::VEC_IRQ[13:0], 2'h3});
      @(posedge clk) {periph_irq, timer_sw_en} <= 2'b01;
      $display("idle test done");
      for (i = 0; i < 4; i++)
      begin
         @(posedge clk) irq_pin_n <= ~i[0];
         repeat (6) @(posedge clk);
         wr(lpm_pkg::MISC_ADDR, {1'b0, i[1:0], 5'h10});
         repeat (2) @(negedge clk);
         chk("option clear", {15'h0, ext_irq_pend_r}, 16'h0000);
         @(posedge clk) irq_pin_n <= i[0];
         repeat (6) @(negedge clk);
         chk("trigger", {15'h0, ext_irq_pend_r}, 16'h0001);
      end
      @(posedge clk) ext_irq_ack <= 1'b1;
      @(posedge clk) ext_irq_ack <= 1'b0;
      wr(lpm_pkg::MISC_ADDR, 8'h60);
      @(posedge clk) irq_pin_n <= 1'b0;
      @(posedge clk) irq_pin_n <= 1'b1;
      repeat (6) @(negedge clk);
      chk("pin disabled", {15'h0, ext_irq_pend_r}, 16'h0000);
      cmd(3);
      repeat (4)
      begin
         r = $random(seed);
         wr(lpm_pkg::MISC_ADDR, r[7:0]);
         rd(lpm_pkg::MISC_ADDR);
         chk("masked write", {8'h00, d}, {8'h00, 8'h60 | (r[7:0] & 8'h02)});
      end
      cmd(2);
      $display("pin test done");
      // Slow select stretches bus tick spacing to 16 * 2; CAN spacing stays at two
      wr(lpm_pkg::MISC_ADDR, 8'h12);
      gap(1'b0, np);
      gap(1'b1, nk);
      chk("slow gaps", {np[7:0], nk[7:0]}, {8'(16 * 2), 8'h02});
      wr(lpm_pkg::MISC_ADDR, 8'h10);
      gap(1'b0, np);
      chk("fast gap", 16'(np), 16'h0002);
      wr(lpm_pkg::MISC_ADDR, 8'h12);
      cmd(1);
      repeat (4) @(posedge clk);
      do_reset();
      rd(lpm_pkg::MISC_ADDR);
      chk("reset misc", {8'h00, d}, 16'h0010);
      $display("slow and reset test done");
      conclude();
   end
endmodule // lpm_ctrl_tb
